/* File: inc/otc_map.vh */
// Register map, field positions, reset values and timing constants of the OVERLAY_ENABLE_BIT timing block
`ifndef OTC_MAP_VH
`define OTC_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OTC_A_LINE        16'h4030
`define OTC_A_MARGIN      16'h4031
`define OTC_A_HDELAY      16'h4032
`define OTC_A_HEIGHT      16'h4033
`define OTC_A_DISP        16'h4034
`define OTC_A_LOCK        16'h4035
`define OTC_A_CAPT        16'h4036
`define OTC_A_SEED        16'h4037

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OTC_R_LINE        8'h20
`define OTC_R_MARGIN      8'h30
`define OTC_R_HDELAY      8'h20
`define OTC_R_HEIGHT      8'h24
`define OTC_R_DISP        8'h00
`define OTC_R_LOCK        8'h01
`define OTC_R_CAPT        8'h24
`define OTC_R_SEED        8'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OTC_B_VSYNC_SEL   7
`define OTC_B_FLY_SEL     6
`define OTC_B_OVERLAY     7
`define OTC_B_BLANK_SEL   6
`define OTC_B_HOLD        7
`define OTC_B_LOCKED      3
`define OTC_B_GATE        7

// ----------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------
`define OTC_CHAR_PIX      11'h00C
`define OTC_MARGIN_UNIT   2
`define OTC_HD_STEP       11'h006
`define OTC_HD_BASE       11'h036
`define OTC_HD_ODD        11'h03C
`define OTC_HD_KNEE       8'h06
`define OTC_FONT_ROWS     12'h012
`define OTC_LOCK_LINES    3'h4
`define OTC_LOCK_THR      12'h002
`define OTC_HF_MUL        26'h0000028
`define OTC_HF_DIV        2'h3
`define OTC_SEED_SHIFT    8
`define OTC_PH_SHIFT      2
`define OTC_FR_SHIFT      6
`define OTC_PER_MIN       24'h000100

`endif

/* File: core/otc_buf2.v */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module otc_buf2 #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg  [W-1:0] mem_q [0:1];
    reg          wr_q;
    reg          rd_q;
    reg  [1:0]   cnt_q;
    wire         push;
    wire         pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ----------------------------------------------------------------
    // Storage entries
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_ent
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    mem_q[i] <= {W{1'b0}};
                else if (push && (wr_q == i))
                    mem_q[i] <= in_data;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pointers and fill count
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
                wr_q <= ~wr_q;
            if (pop)
                rd_q <= ~rd_q;
            if (push && !pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop && !push)
                cnt_q <= cnt_q - 2'h1;
        end
    end

endmodule
`default_nettype wire

/* File: core/otc_timing_core.v */
// OVERLAY_ENABLE_BIT display timing, strip slicing and digital pixel PLL with its control registers
`timescale 1ns/10ps
`default_nettype none
`include "otc_map.vh"

module otc_timing_core (
    input  wire        REF_CLK,
    input  wire        NRST,
    input  wire        SW_RESET,
    input  wire [15:0] REG_ADDR,
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire [7:0]  REG_WDATA,
    output reg  [7:0]  REG_RDATA,
    input  wire        VSYNC_IN,
    input  wire        HORIZONTAL_FLYBACK_IN,
    output wire        OUT_VALID,
    input  wire        OUT_READY,
    output wire [7:0]  OUT_DATA,
    output wire        PIXEL_STALL,
    output reg         PLL_LOCKED,
    output reg         OUTPUTS_ENABLED,
    output reg  [23:0] DIVISION_VALUE,
    output wire        OVERLAY_EN,
    output wire [1:0]  BLINK_RATE,
    output wire [3:0]  PAGE_SEL
);

    localparam ST_WAIT   = 2'h0;
    localparam ST_MARGIN = 2'h1;
    localparam ST_STRIP  = 2'h2;
    localparam [7:0] LOCK_RST   = `OTC_R_LOCK;
    localparam [7:0] CAPT_RST   = `OTC_R_CAPT;
    localparam [7:0] HEIGHT_RST = `OTC_R_HEIGHT;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]  line_q;
    reg  [7:0]  margin_q;
    reg  [7:0]  hdelay_q;
    reg  [5:0]  height_q;
    reg  [7:0]  disp_q;
    reg  [6:0]  lockg_q;
    reg  [6:0]  captg_q;
    reg  [7:0]  seed_q;
    reg         vs_prev_q;
    reg         fly_prev_q;
    reg  [1:0]  state_q;
    reg  [9:0]  vline_q;
    reg  [5:0]  sline_q;
    reg  [10:0] pix_q;
    reg  [25:0] acc_q;
    reg  signed [23:0] freq_q;
    reg  signed [23:0] per_q;
    reg  [2:0]  good_q;
    reg  [7:0]  word_d;
    wire        vsync_sel  = line_q[`OTC_B_VSYNC_SEL];
    wire        fly_sel    = line_q[`OTC_B_FLY_SEL];
    wire [5:0]  line_len   = line_q[5:0];
    wire        blank_sel  = disp_q[`OTC_B_BLANK_SEL];
    wire        pll_hold   = lockg_q[6];
    wire [2:0]  lock_ph    = lockg_q[5:3];
    wire [2:0]  lock_fr    = lockg_q[2:0];
    wire        gate_lock  = captg_q[6];
    wire [2:0]  capt_ph    = captg_q[5:3];
    wire [2:0]  capt_fr    = captg_q[2:0];
    assign OVERLAY_EN = disp_q[`OTC_B_OVERLAY];
    assign BLINK_RATE = disp_q[5:4];
    assign PAGE_SEL   = disp_q[3:0];
    // ----------------------------------------------------------------
    // Reference edges
    // ----------------------------------------------------------------
    wire vs_rise  = VSYNC_IN && !vs_prev_q;
    wire vs_fall  = !VSYNC_IN && vs_prev_q;
    wire fl_rise  = HORIZONTAL_FLYBACK_IN && !fly_prev_q;
    wire fl_fall  = !HORIZONTAL_FLYBACK_IN && fly_prev_q;
    wire vs_ref   = vsync_sel ? vs_rise : vs_fall;
    wire fly_ref  = fly_sel ? fl_fall : fl_rise;

    // ----------------------------------------------------------------
    // Line geometry
    // ----------------------------------------------------------------
    wire [10:0] line_pix  = `OTC_CHAR_PIX * {4'h0, line_len, 1'b1};
    wire [9:0]  margin_ln = {margin_q, 2'b00};
    wire [10:0] hd_ext    = {3'h0, hdelay_q};
    reg  [10:0] hstart;
    always @*
    begin
        if ((hdelay_q <= `OTC_HD_KNEE) && !hdelay_q[0])
            hstart = `OTC_HD_BASE;
        else if ((hdelay_q <= `OTC_HD_KNEE + 8'h01) && hdelay_q[0])
            hstart = `OTC_HD_ODD;
        else
            hstart = (hd_ext * `OTC_HD_STEP) + `OTC_HD_BASE - (`OTC_HD_STEP * `OTC_HD_STEP);
    end
    wire [5:0]  height_nz = (height_q == 6'h00) ? 6'h01 : height_q;
    wire [11:0] slice_num = ({6'h00, sline_q} * (`OTC_FONT_ROWS * 12'h002))
                            + {6'h00, height_nz};
    wire [11:0] slice_den = {5'h00, height_nz, 1'b0};
    wire [11:0] slice_w   = slice_num / slice_den;
    wire [4:0]  slice     = slice_w[4:0];
    // ----------------------------------------------------------------
    // Pixel tick from the high-frequency analysis clock model
    // ----------------------------------------------------------------
    wire        buf_ready;
    wire [25:0] thr       = per_q[23:0] * `OTC_HF_DIV;
    wire        tick      = (acc_q >= thr);
    wire        adv       = tick && buf_ready;
    assign PIXEL_STALL = tick && !buf_ready;
    // ----------------------------------------------------------------
    // Phase error and loop arithmetic
    // ----------------------------------------------------------------
    wire [10:0] half_pix  = {1'b0, line_pix[10:1]};
    wire [11:0] err_raw   = (pix_q < half_pix) ? {1'b0, pix_q}
                            : ({1'b0, pix_q} - {1'b0, line_pix});
    wire signed [23:0] err_x = {{12{err_raw[11]}}, err_raw};
    wire [11:0] err_abs   = err_raw[11] ? (12'h000 - err_raw) : err_raw;
    wire        err_small = (err_abs <= `OTC_LOCK_THR);
    wire [2:0]  gain_ph   = PLL_LOCKED ? lock_ph : capt_ph;
    wire [2:0]  gain_fr   = PLL_LOCKED ? lock_fr : capt_fr;
    wire signed [23:0] ph_term = (err_x <<< gain_ph) >>> `OTC_PH_SHIFT;
    wire signed [23:0] fr_term = (err_x <<< gain_fr) >>> `OTC_FR_SHIFT;
    wire signed [23:0] freq_n  = freq_q + fr_term;
    wire signed [23:0] per_raw = freq_n + ph_term;
    wire signed [23:0] per_min = `OTC_PER_MIN;
    wire signed [23:0] per_n   = (per_raw < per_min) ? per_min : per_raw;
    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            line_q   <= `OTC_R_LINE;
            margin_q <= `OTC_R_MARGIN;
            hdelay_q <= `OTC_R_HDELAY;
            height_q <= HEIGHT_RST[5:0];
            disp_q   <= `OTC_R_DISP;
            lockg_q  <= {LOCK_RST[7:4], LOCK_RST[2:0]};
            captg_q  <= {CAPT_RST[7:4], CAPT_RST[2:0]};
            seed_q   <= `OTC_R_SEED;
        end
        else if (SW_RESET)
        begin
            line_q   <= `OTC_R_LINE;
            margin_q <= `OTC_R_MARGIN;
            hdelay_q <= `OTC_R_HDELAY;
            height_q <= HEIGHT_RST[5:0];
            disp_q   <= `OTC_R_DISP;
            lockg_q  <= {LOCK_RST[7:4], LOCK_RST[2:0]};
            captg_q  <= {CAPT_RST[7:4], CAPT_RST[2:0]};
            seed_q   <= `OTC_R_SEED;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                `OTC_A_LINE:   line_q   <= REG_WDATA;
                `OTC_A_MARGIN: margin_q <= REG_WDATA;
                `OTC_A_HDELAY: hdelay_q <= REG_WDATA;
                `OTC_A_HEIGHT: height_q <= REG_WDATA[5:0];
                `OTC_A_DISP:   disp_q   <= REG_WDATA;
                `OTC_A_LOCK:   lockg_q  <= {REG_WDATA[7:4], REG_WDATA[2:0]};
                `OTC_A_CAPT:   captg_q  <= {REG_WDATA[7:4], REG_WDATA[2:0]};
                `OTC_A_SEED:   seed_q   <= REG_WDATA;
                default:       seed_q   <= seed_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                `OTC_A_LINE:   REG_RDATA <= line_q;
                `OTC_A_MARGIN: REG_RDATA <= margin_q;
                `OTC_A_HDELAY: REG_RDATA <= hdelay_q;
                `OTC_A_HEIGHT: REG_RDATA <= {2'b00, height_q};
                `OTC_A_DISP:   REG_RDATA <= disp_q;
                `OTC_A_LOCK:   REG_RDATA <= {lockg_q[6:3], PLL_LOCKED, lockg_q[2:0]};
                `OTC_A_CAPT:   REG_RDATA <= {captg_q[6:3], 1'b0, captg_q[2:0]};
                `OTC_A_SEED:   REG_RDATA <= seed_q;
                default:       REG_RDATA <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Digital PLL: period, lock detect, pixel tick accumulator
    // ----------------------------------------------------------------
    always @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            vs_prev_q      <= 1'b0;
            fly_prev_q     <= 1'b0;
            freq_q         <= 24'sh000600;
            per_q          <= 24'sh000600;
            acc_q          <= 26'h0000000;
            good_q         <= 3'h0;
            PLL_LOCKED     <= 1'b0;
            DIVISION_VALUE <= 24'h000600;
        end
        else if (SW_RESET)
        begin
            vs_prev_q      <= VSYNC_IN;
            fly_prev_q     <= HORIZONTAL_FLYBACK_IN;
            freq_q         <= {8'h00, `OTC_R_SEED, 8'h00};
            per_q          <= {8'h00, `OTC_R_SEED, 8'h00};
            acc_q          <= 26'h0000000;
            good_q         <= 3'h0;
            PLL_LOCKED     <= 1'b0;
            DIVISION_VALUE <= {8'h00, `OTC_R_SEED, 8'h00};
        end
        else
        begin
            vs_prev_q  <= VSYNC_IN;
            fly_prev_q <= HORIZONTAL_FLYBACK_IN;
            if (REG_WR && (REG_ADDR == `OTC_A_SEED))
            begin
                freq_q <= {8'h00, REG_WDATA, 8'h00};
                per_q  <= {8'h00, REG_WDATA, 8'h00};
                DIVISION_VALUE <= {8'h00, REG_WDATA, 8'h00};
            end
            else if (fly_ref && !pll_hold)
            begin
                freq_q         <= freq_n;
                per_q          <= per_n;
                DIVISION_VALUE <= per_n;
            end
            if (fly_ref)
            begin
                if (!err_small)
                begin
                    good_q     <= 3'h0;
                    PLL_LOCKED <= 1'b0;
                end
                else if (good_q != `OTC_LOCK_LINES)
                begin
                    good_q     <= good_q + 3'h1;
                    PLL_LOCKED <= (good_q + 3'h1 == `OTC_LOCK_LINES);
                end
            end
            if (adv)
                acc_q <= acc_q - thr + `OTC_HF_MUL;
            else if (!tick)
                acc_q <= acc_q + `OTC_HF_MUL;
        end
    end

    // ----------------------------------------------------------------
    // Horizontal pixel counter and vertical sequencer
    // ----------------------------------------------------------------
    always @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pix_q   <= 11'h000;
            state_q <= ST_WAIT;
            vline_q <= 10'h000;
            sline_q <= 6'h00;
        end
        else if (SW_RESET)
        begin
            pix_q   <= 11'h000;
            state_q <= ST_WAIT;
            vline_q <= 10'h000;
            sline_q <= 6'h00;
        end
        else
        begin
            if (fly_ref)
                pix_q <= 11'h000;
            else if (adv)
                pix_q <= (pix_q >= line_pix - 11'h001) ? 11'h000 : pix_q + 11'h001;
            if (vs_ref)
            begin
                vline_q <= 10'h000;
                sline_q <= 6'h00;
                state_q <= (margin_ln == 10'h000) ? ST_STRIP : ST_MARGIN;
            end
            else if (fly_ref)
            begin
                case (state_q)
                    ST_MARGIN:
                    begin
                        vline_q <= vline_q + 10'h001;
                        if (vline_q + 10'h001 >= margin_ln)
                            state_q <= ST_STRIP;
                    end
                    ST_STRIP:
                        sline_q <= (sline_q >= height_nz - 6'h01) ? 6'h00
                                   : sline_q + 6'h01;
                    default:
                        state_q <= state_q;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Pixel word and output gating
    // ----------------------------------------------------------------
    wire enabled = OVERLAY_EN && (!gate_lock || PLL_LOCKED);
    always @*
    begin
        word_d = 8'h00;
        case (state_q)
            ST_MARGIN:
                word_d = {enabled && blank_sel, 1'b0, 1'b1, 5'h00};
            ST_STRIP:
                word_d = {enabled && (pix_q >= hstart), enabled && (pix_q >= hstart),
                          1'b0, slice};
            default:
                word_d = 8'h00;
        endcase
    end

    always @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
            OUTPUTS_ENABLED <= 1'b0;
        else
            OUTPUTS_ENABLED <= !gate_lock || PLL_LOCKED;
    end

    otc_buf2 #(
        .W (8)
    ) u_buf (
        .clk       (REF_CLK),
        .rst_n     (NRST),
        .in_valid  (tick),
        .in_ready  (buf_ready),
        .in_data   (word_d),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (OUT_DATA)
    );

endmodule
`default_nettype wire

/* File: tb/otc_tb_monitor.sv */
// Port checker for the OVERLAY_ENABLE_BIT timing core
`timescale 1ns/10ps
`default_nettype none
`include "otc_map.vh"

module otc_tb_monitor (
    input wire logic        REF_CLK,
    input wire logic        NRST,
    input wire logic        SW_RESET,
    input wire logic [15:0] REG_ADDR,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    input wire logic        VSYNC_IN,
    input wire logic        HORIZONTAL_FLYBACK_IN,
    input wire logic        OUT_VALID,
    input wire logic        OUT_READY,
    input wire logic [7:0]  OUT_DATA,
    input wire logic        PIXEL_STALL,
    input wire logic        PLL_LOCKED,
    input wire logic        OUTPUTS_ENABLED,
    input wire logic [23:0] DIVISION_VALUE,
    input wire logic        OVERLAY_EN,
    input wire logic [1:0]  BLINK_RATE,
    input wire logic [3:0]  PAGE_SEL
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // ------------------------------------------------------------
    // Recent flyback edges, writes and software resets
    // ------------------------------------------------------------
    logic       fly_q;
    logic [5:0] ev_q;
    logic [7:0] wd_q;
    wire        ev_now = (HORIZONTAL_FLYBACK_IN != fly_q) || REG_WR || SW_RESET;
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            fly_q <= 1'b0;
            ev_q  <= 6'h00;
            wd_q  <= 8'h00;
        end
        else
        begin
            fly_q <= HORIZONTAL_FLYBACK_IN;
            ev_q  <= {ev_q[4:0], ev_now};
            wd_q  <= REG_WDATA;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_lock_rd;
        REG_RD && REG_ADDR == `OTC_A_LOCK;
    endsequence
    sequence s_sw_pulse;
        SW_RESET && !REG_WR;
    endsequence
    sequence s_sw_after;
        !PLL_LOCKED && !OVERLAY_EN && PAGE_SEL == 4'h0 && DIVISION_VALUE == 24'h000600
        ##1 OUTPUTS_ENABLED;
    endsequence
    chk_lock_read: assert property (s_lock_rd |=> REG_RDATA[3] == $past(PLL_LOCKED))
        else $error("lock flag read differs from lock state");
    chk_unmapped_read: assert property (REG_RD && REG_ADDR[15:3] != 13'h0806 |=> REG_RDATA == 8'h00)
        else $error("unmapped read returned data");
    chk_disp_fields: assert property (REG_WR && REG_ADDR == `OTC_A_DISP && !SW_RESET |=>
        {OVERLAY_EN, BLINK_RATE, PAGE_SEL} == {wd_q[7], wd_q[5:4], wd_q[3:0]})
        else $error("display control outputs wrong after write");
    chk_sw_defaults: assert property (s_sw_pulse |=> s_sw_after)
        else $error("software reset left state behind");
    chk_lock_enables: assert property (PLL_LOCKED [*2] |-> OUTPUTS_ENABLED)
        else $error("outputs disabled while locked");
    chk_period_cause: assert property ($changed(DIVISION_VALUE) |-> ev_q != 6'h00)
        else $error("pixel period moved without a line or write");
    chk_lock_cause: assert property ($rose(PLL_LOCKED) |-> ev_q != 6'h00)
        else $error("lock rose without a flyback edge");
    chk_stream_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
        else $error("stalled word changed or vanished");
    chk_stall_full: assert property (PIXEL_STALL |-> OUT_VALID)
        else $error("stall reported with empty buffer");
endmodule
`default_nettype wire

/* File: tb/otc_video_src.sv */
// Video path model: flyback, vertical sync and a stalling pixel receiver
`timescale 1ns/10ps
`default_nettype none

module otc_video_src (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] line_cycles,
    input  wire logic        stall,
    output var  logic        vsync,
    output var  logic        flyback,
    output var  logic        ready
);
    logic [11:0] cyc_q;
    logic [3:0]  line_q;
    // ------------------------------------------------------------
    // Line and frame timing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_q   <= 12'h000;
            line_q  <= 4'h0;
            flyback <= 1'b0;
            vsync   <= 1'b1;
            ready   <= 1'b1;
        end
        else
        begin
            cyc_q   <= (cyc_q >= line_cycles - 12'h001) ? 12'h000 : cyc_q + 12'h001;
            line_q  <= (cyc_q == 12'h000) ? line_q + 4'h1 : line_q;
            flyback <= (cyc_q < 12'h010);
            vsync   <= (line_q != 4'h0);
            ready   <= !stall;
        end
    end
endmodule
`default_nettype wire

/* File: tb/otc_tb.sv */
// Self-checking bench for the OVERLAY_ENABLE_BIT timing core
`timescale 1ns/10ps
`default_nettype none
`include "otc_map.vh"

module testbench;
    logic        REF_CLK     = 1'b0;
    logic        NRST        = 1'b0;
    logic        SW_RESET    = 1'b0;
    logic [15:0] REG_ADDR    = 16'h0000;
    logic        REG_WR      = 1'b0;
    logic        REG_RD      = 1'b0;
    logic [7:0]  REG_WDATA   = 8'h00;
    logic [11:0] line_cycles = 12'h2BC;
    logic        stall       = 1'b0;
    int          failures    = 0;
    int          check_count = 0;
    wire  [7:0]  REG_RDATA, OUT_DATA;
    wire  [23:0] DIVISION_VALUE;
    wire  [1:0]  BLINK_RATE;
    wire  [3:0]  PAGE_SEL;
    wire         VSYNC_IN, HORIZONTAL_FLYBACK_IN, OUT_VALID, OUT_READY, PIXEL_STALL;
    wire         PLL_LOCKED, OUTPUTS_ENABLED, OVERLAY_EN;
    logic [7:0]  rst_tab [0:7] = '{`OTC_R_LINE, `OTC_R_MARGIN, `OTC_R_HDELAY, `OTC_R_HEIGHT,
                                   `OTC_R_DISP, `OTC_R_LOCK, `OTC_R_CAPT, `OTC_R_SEED};
    logic [7:0]  wr_tab [0:7]  = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0]  exp_tab [0:7] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hF7, 8'hF7, 8'hFF};

    always #50 REF_CLK = ~REF_CLK;

    otc_timing_core i_otc_timing_core (
        .REF_CLK(REF_CLK), .NRST(NRST), .SW_RESET(SW_RESET), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .VSYNC_IN(VSYNC_IN), .HORIZONTAL_FLYBACK_IN(HORIZONTAL_FLYBACK_IN),
        .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
        .PIXEL_STALL(PIXEL_STALL), .PLL_LOCKED(PLL_LOCKED), .OUTPUTS_ENABLED(OUTPUTS_ENABLED),
        .DIVISION_VALUE(DIVISION_VALUE), .OVERLAY_EN(OVERLAY_EN), .BLINK_RATE(BLINK_RATE),
        .PAGE_SEL(PAGE_SEL)
    );
    otc_video_src i_otc_video_src (
        .clk(REF_CLK), .rst_n(NRST), .line_cycles(line_cycles), .stall(stall),
        .vsync(VSYNC_IN), .flyback(HORIZONTAL_FLYBACK_IN), .ready(OUT_READY)
    );
    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge REF_CLK);
        REG_WR    <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge REF_CLK);
        REG_RD   <= 1'b0;
        @(posedge REF_CLK);
        check($sformatf("reg %h", a), {16'h0000, exp}, {16'h0000, REG_RDATA});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 8; i++)
            rdchk(`OTC_A_LINE + 16'(i), rst_tab[i]);
        rdchk(16'h4038, 8'h00);
        for (int i = 0; i < 8; i++)
            wr(`OTC_A_LINE + 16'(i), wr_tab[i]);
        for (int i = 0; i < 8; i++)
            rdchk(`OTC_A_LINE + 16'(i), exp_tab[i]);
        @(posedge REF_CLK);
        SW_RESET <= 1'b1;
        @(posedge REF_CLK);
        SW_RESET <= 1'b0;
        for (int i = 0; i < 8; i++)
            rdchk(`OTC_A_LINE + 16'(i), rst_tab[i]);
    endtask
    task automatic t_lock;
        logic [23:0] dv;
        int          n;
        wr(`OTC_A_LINE, 8'h01);
        wr(`OTC_A_LOCK, 8'h22);
        wr(`OTC_A_CAPT, 8'hA2);
        wr(`OTC_A_SEED, 8'h01);
        @(negedge REF_CLK);
        check("seeded period", 24'h000100, DIVISION_VALUE);
        check("gated while unlocked", 24'h0, {23'h0, OUTPUTS_ENABLED});
        for (n = 0; n < 30000 && PLL_LOCKED !== 1'b1; n++)
            @(negedge REF_CLK);
        check("locked", 24'h1, {23'h0, PLL_LOCKED});
        rdchk(`OTC_A_LOCK, 8'h2A);
        @(negedge REF_CLK);
        check("enabled while locked", 24'h1, {23'h0, OUTPUTS_ENABLED});
        n = 0;
        repeat (700)
        begin
            @(negedge REF_CLK);
            if (OUT_VALID === 1'b1 && OUT_READY === 1'b1)
                n++;
        end
        check("words per line", 24'h1, {23'h0, n >= 34 && n <= 38});
        wr(`OTC_A_LOCK, 8'hAA);
        repeat (2) @(negedge REF_CLK);
        dv = DIVISION_VALUE;
        line_cycles <= 12'h320;
        repeat (2400) @(negedge REF_CLK);
        check("held period", dv, DIVISION_VALUE);
        wr(`OTC_A_LOCK, 8'h22);
        for (n = 0; n < 2000 && PLL_LOCKED !== 1'b0; n++)
            @(negedge REF_CLK);
        repeat (2) @(negedge REF_CLK);
        check("gated after unlock", 24'h0, {23'h0, OUTPUTS_ENABLED});
        repeat (1600) @(negedge REF_CLK);
        check("period tracks line", 24'h1, {23'h0, DIVISION_VALUE > dv});
    endtask
    task automatic t_stall;
        int n;
        stall <= 1'b1;
        for (n = 0; n < 500 && PIXEL_STALL !== 1'b1; n++)
            @(negedge REF_CLK);
        check("stall when full", 24'h3, {22'h0, PIXEL_STALL, OUT_VALID});
        check("dark while overlay off", 24'h0, {22'h0, OUT_DATA[7:6]});
        repeat (50) @(negedge REF_CLK);
        stall <= 1'b0;
        for (n = 0; n < 60 && OUT_VALID !== 1'b0; n++)
            @(negedge REF_CLK);
        check("drained", 24'h0, {23'h0, OUT_VALID});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge REF_CLK);
        NRST <= 1'b1;
        t_regs();
        t_lock();
        t_stall();
        tally_and_finish();
    end
    initial
    begin
        #5000000;
        failures++;
        tally_and_finish();
    end
endmodule

bind otc_timing_core otc_tb_monitor i_otc_tb_monitor (
    .REF_CLK(REF_CLK), .NRST(NRST), .SW_RESET(SW_RESET), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .VSYNC_IN(VSYNC_IN), .HORIZONTAL_FLYBACK_IN(HORIZONTAL_FLYBACK_IN),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
    .PIXEL_STALL(PIXEL_STALL), .PLL_LOCKED(PLL_LOCKED), .OUTPUTS_ENABLED(OUTPUTS_ENABLED),
    .DIVISION_VALUE(DIVISION_VALUE), .OVERLAY_EN(OVERLAY_EN), .BLINK_RATE(BLINK_RATE),
    .PAGE_SEL(PAGE_SEL)
);
`default_nettype wire
